// File: verilog/isp_defines.vh
// Constants for the interrupt unit and serial host port.
`ifndef ISP_DEFINES_VH
`define ISP_DEFINES_VH

// Register offsets on the serial port.
`define ISP_ADDR_TRACE_ADDR   8'h00
`define ISP_ADDR_TRACE_DATA   8'h01
`define ISP_ADDR_PIN_CTRL     8'h03
`define ISP_ADDR_FLAGS        8'h04
`define ISP_ADDR_MASK         8'h05

// Reset values.
`define ISP_RST_TRACE         8'h00
`define ISP_RST_PIN_CTRL      8'h00
`define ISP_RST_FLAGS         8'hff
`define ISP_RST_MASK          8'h00

// Field positions in pin_function_control.
`define ISP_BIT_RUN_SEL       0
`define ISP_BIT_IRQ_SEL       1
`define ISP_BIT_CLK_SEL       2
`define ISP_BIT_POL           5

// Field positions in event_flags and event_mask.
`define ISP_BIT_WAKE_A        0
`define ISP_BIT_SYNC_A        1
`define ISP_BIT_MID_A         2
`define ISP_BIT_EOM_A         3
`define ISP_BIT_WAKE_B        4
`define ISP_BIT_SYNC_B        5
`define ISP_BIT_MID_B         6
`define ISP_BIT_EOM_B         7

// Instruction codes.
`define ISP_INSTR_WRITE       8'h02
`define ISP_INSTR_READ        8'h03
`define ISP_INSTR_FIFO        8'h04

// Payload bytes sent before the status byte on a FIFO read.
`define ISP_FIFO_DATA_BYTES   3'd4

`endif

// File: verilog/isp_spi_shift.v
// Serial clock edge detection and receive shifter for the host port.
`timescale 1ns/10ps
`include "isp_defines.vh"

module isp_spi_shift (
  // Clock and reset.
  input  wire       clk_in,
  input  wire       rst_n_in,
  // Serial pins.
  input  wire       sck_in,
  input  wire       chip_select_n_in,
  input  wire       sdi_in,
  // Edge pulses and received byte.
  output wire       rise_out,
  output wire       fall_out,
  output reg        byte_done_out,
  output reg  [7:0] rx_byte_out
);

  reg       sck_q;
  reg [2:0] bit_cnt;
  reg [6:0] shift;

  // Edges count only while selected.
  assign rise_out = sck_in & ~sck_q & ~chip_select_n_in;
  assign fall_out = ~sck_in & sck_q & ~chip_select_n_in;

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sck_q         <= 1'b0;
      bit_cnt       <= 3'h0;
      shift         <= 7'h00;
      byte_done_out <= 1'b0;
      rx_byte_out   <= 8'h00;
    end
    else
    begin
      sck_q         <= sck_in;
      byte_done_out <= 1'b0;
      if (chip_select_n_in)
      begin
        bit_cnt <= 3'h0;
      end
      else if (rise_out)
      begin
        // Most significant bit arrives first.
        shift   <= {shift[5:0], sdi_in};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7)
        begin
          rx_byte_out   <= {shift, sdi_in};
          byte_done_out <= 1'b1;
        end
      end
    end
  end

endmodule // isp_spi_shift

// File: verilog/isp_pin_mux.v
// Output pin function selection for the three shared pins.
`timescale 1ns/10ps
`include "isp_defines.vh"

module isp_pin_mux (
  // Clock and reset.
  input  wire       clk_in,
  input  wire       rst_n_in,
  // Selection bits.
  input  wire [7:0] pin_function_control_in,
  // Pin sources.
  input  wire       irq_level_in,
  input  wire       rx_strobe_in,
  input  wire       rx_data_in,
  input  wire       clk_div_in,
  input  wire       rx_running_in,
  // Pins.
  output reg        irq_strobe_pin_out,
  output reg        clock_data_pin_out,
  output reg        running_data_pin_out
);

  wire clock_or_data_pin_select   = pin_function_control_in[`ISP_BIT_CLK_SEL];
  wire irq_or_strobe_pin_select   = pin_function_control_in[`ISP_BIT_IRQ_SEL];
  wire running_or_data_pin_select = pin_function_control_in[`ISP_BIT_RUN_SEL];

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      irq_strobe_pin_out   <= 1'b0;
      clock_data_pin_out   <= 1'b0;
      running_data_pin_out <= 1'b0;
    end
    else
    begin
      clock_data_pin_out   <= clock_or_data_pin_select ? rx_data_in : clk_div_in;
      irq_strobe_pin_out   <= irq_or_strobe_pin_select ? rx_strobe_in : irq_level_in;
      running_data_pin_out <= running_or_data_pin_select ? rx_data_in : rx_running_in;
    end
  end

endmodule // isp_pin_mux

// File: verilog/isp_irq_host_port.v
// Interrupt generation unit and serial host register port.
`timescale 1ns/10ps
`include "isp_defines.vh"

module isp_irq_host_port (
  // Clock and reset.
  input  wire       clk_in,
  input  wire       rst_n_in,
  // Serial host port.
  input  wire       chip_select_n_in,
  input  wire       sck_in,
  input  wire       sdi_in,
  output reg        sdo_out,
  // Receiver events, one-cycle pulses.
  input  wire [7:0] event_in,
  input  wire       reset_event_in,
  // FIFO and run mode.
  input  wire       fifo_lock_in,
  input  wire       slave_run_in,
  input  wire       fifo_bit_in,
  input  wire [7:0] fifo_status_in,
  output reg        fifo_pop_out,
  output reg        fifo_read_done_out,
  // Pin sources.
  input  wire       rx_strobe_in,
  input  wire       rx_data_in,
  input  wire       clk_div_in,
  input  wire       rx_running_in,
  // Pins.
  output wire       irq_strobe_pin_out,
  output wire       clock_data_pin_out,
  output wire       running_data_pin_out,
  // Register contents for the rest of the chip.
  output reg  [7:0] pin_function_control_out,
  output reg  [7:0] event_flags_out
);

  localparam ST_INSTR = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_WDATA = 3'h2;
  localparam ST_RDATA = 3'h3;
  localparam ST_FIFO  = 3'h4;

  reg  [2:0] state;
  reg        is_write;
  reg  [7:0] addr;
  reg  [7:0] tx_reg;
  reg  [2:0] fifo_bytes;
  reg  [7:0] event_mask;
  reg  [7:0] last_write_address_trace;
  reg  [7:0] last_write_data_trace;
  reg        reset_hold;
  reg        eom_stuck;
  reg        irq_level;
  reg  [7:0] next_flags;
  reg        next_reset_hold;
  reg  [7:0] read_value;

  wire       rise;
  wire       fall;
  wire       byte_done;
  wire [7:0] rx_byte;
  wire       status_read;
  wire       pending;
  wire       eom_event;

  // Flags that a given set of events wipes out.
  function [7:0] event_clears;
    input [7:0] ev;
    reg   [7:0] c;
    begin
      c = 8'h00;
      if (ev[`ISP_BIT_WAKE_A])
      begin
        c[`ISP_BIT_SYNC_A] = 1'b1;
        c[`ISP_BIT_SYNC_B] = 1'b1;
        c[`ISP_BIT_WAKE_B] = 1'b1;
      end
      if (ev[`ISP_BIT_WAKE_B])
      begin
        c[`ISP_BIT_SYNC_A] = 1'b1;
        c[`ISP_BIT_SYNC_B] = 1'b1;
        c[`ISP_BIT_WAKE_A] = 1'b1;
      end
      if (ev[`ISP_BIT_SYNC_A])
      begin
        c[`ISP_BIT_EOM_A]  = 1'b1;
        c[`ISP_BIT_EOM_B]  = 1'b1;
        c[`ISP_BIT_MID_A]  = 1'b1;
        c[`ISP_BIT_MID_B]  = 1'b1;
        c[`ISP_BIT_SYNC_B] = 1'b1;
      end
      if (ev[`ISP_BIT_SYNC_B])
      begin
        c[`ISP_BIT_EOM_A]  = 1'b1;
        c[`ISP_BIT_EOM_B]  = 1'b1;
        c[`ISP_BIT_MID_A]  = 1'b1;
        c[`ISP_BIT_MID_B]  = 1'b1;
        c[`ISP_BIT_SYNC_A] = 1'b1;
      end
      event_clears = c;
    end
  endfunction

  isp_spi_shift u_shift (
    .clk_in           (clk_in),
    .rst_n_in         (rst_n_in),
    .sck_in           (sck_in),
    .chip_select_n_in (chip_select_n_in),
    .sdi_in           (sdi_in),
    .rise_out         (rise),
    .fall_out         (fall),
    .byte_done_out    (byte_done),
    .rx_byte_out      (rx_byte)
  );

  isp_pin_mux u_pins (
    .clk_in                  (clk_in),
    .rst_n_in                (rst_n_in),
    .pin_function_control_in (pin_function_control_out),
    .irq_level_in            (irq_level),
    .rx_strobe_in            (rx_strobe_in),
    .rx_data_in              (rx_data_in),
    .clk_div_in              (clk_div_in),
    .rx_running_in           (rx_running_in),
    .irq_strobe_pin_out      (irq_strobe_pin_out),
    .clock_data_pin_out      (clock_data_pin_out),
    .running_data_pin_out    (running_data_pin_out)
  );

  // A read of the flags register clears it once the address is taken.
  assign status_read = byte_done & (state == ST_ADDR) & ~is_write &
                       (rx_byte == `ISP_ADDR_FLAGS);

  assign pending   = |(event_flags_out & ~event_mask);
  assign eom_event = event_in[`ISP_BIT_EOM_A] | event_in[`ISP_BIT_EOM_B];

  // Register read decode; write-only and unmapped offsets read as zero.
  always @*
  begin
    case (rx_byte)
      `ISP_ADDR_TRACE_ADDR: read_value = last_write_address_trace;
      `ISP_ADDR_TRACE_DATA: read_value = last_write_data_trace;
      `ISP_ADDR_FLAGS:      read_value = event_flags_out;
      default:              read_value = 8'h00;
    endcase
  end

  // Flag update; a new event wins over a status-read clear in the same cycle.
  always @*
  begin
    next_flags      = event_flags_out;
    next_reset_hold = reset_hold;
    if (status_read)
    begin
      next_flags = 8'h00;
    end
    next_flags = (next_flags & ~event_clears(event_in)) | event_in;
    if (reset_hold && (|event_in))
    begin
      // Any event, masked or not, ends the reset indication.
      next_flags      = 8'h00;
      next_reset_hold = 1'b0;
    end
    if (reset_event_in)
    begin
      next_flags      = `ISP_RST_FLAGS;
      next_reset_hold = 1'b1;
    end
  end

  // Flags, reset indication, stuck end-of-message and the pin level.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      event_flags_out <= `ISP_RST_FLAGS;
      reset_hold      <= 1'b1;
      eom_stuck       <= 1'b0;
      irq_level       <= 1'b0;
    end
    else
    begin
      event_flags_out <= next_flags;
      reset_hold      <= next_reset_hold;
      if (reset_event_in)
      begin
        eom_stuck <= 1'b0;
      end
      else if (eom_event && fifo_lock_in && slave_run_in)
      begin
        eom_stuck <= 1'b1;
      end
      else if (fifo_read_done_out)
      begin
        eom_stuck <= 1'b0;
      end
      if (next_reset_hold)
      begin
        // Reset indication drives low whatever the polarity or mask.
        irq_level <= 1'b0;
      end
      else if (pin_function_control_out[`ISP_BIT_POL])
      begin
        irq_level <= pending | eom_stuck;
      end
      else
      begin
        irq_level <= ~(pending | eom_stuck);
      end
    end
  end

  // Serial command sequencer and register writes.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state                    <= ST_INSTR;
      is_write                 <= 1'b0;
      addr                     <= 8'h00;
      tx_reg                   <= 8'h00;
      sdo_out                  <= 1'b0;
      fifo_bytes               <= 3'h0;
      fifo_pop_out             <= 1'b0;
      fifo_read_done_out       <= 1'b0;
      pin_function_control_out <= `ISP_RST_PIN_CTRL;
      event_mask               <= `ISP_RST_MASK;
      last_write_address_trace <= `ISP_RST_TRACE;
      last_write_data_trace    <= `ISP_RST_TRACE;
    end
    else
    begin
      fifo_pop_out       <= 1'b0;
      fifo_read_done_out <= 1'b0;
      if (chip_select_n_in)
      begin
        // Deselect aborts any frame; the next select starts afresh.
        state <= ST_INSTR;
      end
      else
      begin
        if (fall)
        begin
          if ((state == ST_FIFO) && (fifo_bytes < `ISP_FIFO_DATA_BYTES))
          begin
            // Payload leaves in the order it was received.
            sdo_out      <= fifo_bit_in;
            fifo_pop_out <= 1'b1;
          end
          else
          begin
            sdo_out <= tx_reg[7];
            tx_reg  <= {tx_reg[6:0], 1'b0};
          end
        end
        if (byte_done)
        begin
          case (state)
            ST_INSTR:
            begin
              // Each frame opens with an instruction byte.
              case (rx_byte)
                `ISP_INSTR_WRITE:
                begin
                  is_write <= 1'b1;
                  state    <= ST_ADDR;
                end
                `ISP_INSTR_READ:
                begin
                  is_write <= 1'b0;
                  state    <= ST_ADDR;
                end
                `ISP_INSTR_FIFO:
                begin
                  fifo_bytes <= 3'h0;
                  state      <= ST_FIFO;
                end
                default:
                begin
                  state <= ST_INSTR;
                end
              endcase
            end
            ST_ADDR:
            begin
              addr <= rx_byte;
              if (is_write)
              begin
                state <= ST_WDATA;
              end
              else
              begin
                tx_reg <= read_value;
                state  <= ST_RDATA;
              end
            end
            ST_WDATA:
            begin
              case (addr)
                `ISP_ADDR_PIN_CTRL: pin_function_control_out <= rx_byte;
                `ISP_ADDR_MASK:     event_mask               <= rx_byte;
                default:            event_mask               <= event_mask;
              endcase
              last_write_address_trace <= addr;
              last_write_data_trace    <= rx_byte;
              state                    <= ST_INSTR;
            end
            ST_RDATA:
            begin
              state <= ST_INSTR;
            end
            ST_FIFO:
            begin
              fifo_bytes <= fifo_bytes + 3'h1;
              if (fifo_bytes == `ISP_FIFO_DATA_BYTES - 3'h1)
              begin
                tx_reg <= fifo_status_in;
              end
              else if (fifo_bytes == `ISP_FIFO_DATA_BYTES)
              begin
                fifo_read_done_out <= 1'b1;
                state              <= ST_INSTR;
              end
            end
            default:
            begin
              state <= ST_INSTR;
            end
          endcase
        end
      end
    end
  end

endmodule // isp_irq_host_port

// File: sim/isp_host_model.sv
// Serial host master model driving the register port of the interrupt unit.
`timescale 1ns/10ps

module isp_host_model (
  // Clock.
  input  wire clk_in,
  // Serial pins.
  output reg  sck_out,
  output reg  chip_select_n_out,
  output reg  sdi_out,
  input  wire sdo_in
);
  initial
  begin
    sck_out = 1'b0;
    chip_select_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // Settles the clock low before select moves; a released data line shows the inverse of its last bit.
  task sel(input reg on);
  begin
    @(negedge clk_in);
    sck_out <= 1'b0;
    repeat (3) @(negedge clk_in);
    chip_select_n_out <= !on;
    if (!on)
      sdi_out <= ~sdi_out;
    repeat (3) @(negedge clk_in);
  end
  endtask

  // One byte out and in; each clock phase lasts three system cycles.
  task xfer(input reg [7:0] tx, output reg [7:0] rx);
    integer i;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      sck_out <= 1'b0;
      sdi_out <= tx[i];
      repeat (3) @(negedge clk_in);
      sck_out <= 1'b1;
      rx[i] = sdo_in;
      repeat (3) @(negedge clk_in);
    end
  end
  endtask
endmodule // isp_host_model

// File: sim/isp_irq_host_port_chk.sv
// Assertion checker for the interrupt unit and serial host port.
`timescale 1ns/10ps

module isp_irq_host_port_chk (
  // Clock and reset.
  input wire       clk_in,
  input wire       rst_n_in,
  // Observed ports.
  input wire       chip_select_n_in,
  input wire       sck_in,
  input wire       sdo_out,
  input wire [7:0] event_in,
  input wire       reset_event_in,
  input wire       fifo_lock_in,
  input wire       fifo_pop_out,
  input wire       fifo_read_done_out,
  input wire       rx_strobe_in,
  input wire       rx_data_in,
  input wire       clk_div_in,
  input wire       rx_running_in,
  input wire       irq_strobe_pin_out,
  input wire       clock_data_pin_out,
  input wire       running_data_pin_out,
  input wire [7:0] pin_function_control_out,
  input wire [7:0] event_flags_out
);
  reg        ind;
  reg  [5:0] pops;
  wire [7:0] ctl = pin_function_control_out;
  wire       live = !ind && !reset_event_in;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Mirrors the reset indication that swallows the next event.
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      ind <= 1'b1;
    else if (reset_event_in)
      ind <= 1'b1;
    else if (|event_in)
      ind <= 1'b0;

  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      pops <= 6'h00;
    else if (chip_select_n_in || fifo_read_done_out)
      pops <= 6'h00;
    else if (fifo_pop_out)
      pops <= pops + 6'h01;

  sequence s_rst_ev;
    reset_event_in;
  endsequence
  sequence s_first_ev;
    ind && !reset_event_in && event_in != 8'h00;
  endsequence
  sequence s_quiet;
    !ind && !reset_event_in && event_flags_out == 8'h00 && !fifo_lock_in && !ctl[1];
  endsequence

  clock_pin_a: assert property ($past(rst_n_in) |->
    clock_data_pin_out == ($past(ctl[2]) ? $past(rx_data_in) : $past(clk_div_in)))
    else $error("clock data pin source wrong");
  strobe_pin_a: assert property ($past(rst_n_in) && $past(ctl[1]) |->
    irq_strobe_pin_out == $past(rx_strobe_in))
    else $error("strobe not on irq pin");
  run_pin_a: assert property ($past(rst_n_in) |->
    running_data_pin_out == ($past(ctl[0]) ? $past(rx_data_in) : $past(rx_running_in)))
    else $error("running data pin source wrong");
  flag_set_a: assert property (live |=> (event_flags_out & $past(event_in)) == $past(event_in))
    else $error("event flag not set");
  wake_clear_a: assert property (live && event_in[4] && !event_in[5] && event_in[1:0] == 2'b00 |=>
    !event_flags_out[5] && event_flags_out[1:0] == 2'b00)
    else $error("wake did not clear flags");
  sync_clear_a: assert property (live && event_in[1] && event_in[7:5] == 3'h0 && event_in[3:2] == 2'b00 |=>
    event_flags_out[7:5] == 3'h0 && event_flags_out[3:2] == 2'b00)
    else $error("sync did not clear flags");
  reset_event_a: assert property (s_rst_ev |=> event_flags_out == 8'hff ##1 (ctl[1] || !irq_strobe_pin_out))
    else $error("reset event not taken");
  first_event_a: assert property (s_first_ev |=> event_flags_out == 8'h00)
    else $error("first event did not clear flags");
  irq_polarity_a: assert property (s_quiet ##1 !ctl[1] |=> irq_strobe_pin_out == !$past(ctl[5], 2))
    else $error("idle irq level wrong");
  sdo_edge_a: assert property ($changed(sdo_out) && !$past(chip_select_n_in) && $past(rst_n_in, 2) |->
    $past(sck_in) == 1'b0 && $past(sck_in, 2) == 1'b1)
    else $error("sdo moved without clock fall");
  fifo_count_a: assert property (fifo_read_done_out |-> pops == 6'd32)
    else $error("payload bit count wrong");
endmodule // isp_irq_host_port_chk

bind isp_irq_host_port isp_irq_host_port_chk i_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .chip_select_n_in(chip_select_n_in), .sck_in(sck_in),
  .sdo_out(sdo_out), .event_in(event_in), .reset_event_in(reset_event_in), .fifo_lock_in(fifo_lock_in),
  .fifo_pop_out(fifo_pop_out), .fifo_read_done_out(fifo_read_done_out), .rx_strobe_in(rx_strobe_in),
  .rx_data_in(rx_data_in), .clk_div_in(clk_div_in), .rx_running_in(rx_running_in),
  .irq_strobe_pin_out(irq_strobe_pin_out), .clock_data_pin_out(clock_data_pin_out),
  .running_data_pin_out(running_data_pin_out), .pin_function_control_out(pin_function_control_out),
  .event_flags_out(event_flags_out)
);

// File: sim/isp_irq_host_port_tb.sv
// Self-checking testbench for the interrupt unit and serial host port.
`timescale 1ns/10ps
`include "isp_defines.vh"

module isp_irq_host_port_tb;
  reg         clk_in = 1'b0;
  reg         rst_n_in = 1'b0;
  reg  [7:0]  event_in;
  reg         reset_event_in;
  reg         fifo_lock_in;
  reg         slave_run_in;
  reg  [7:0]  fifo_status_in;
  reg         rx_strobe_in;
  reg         rx_data_in;
  reg         clk_div_in;
  reg         rx_running_in;
  reg  [4:0]  fifo_idx = 5'h00;
  reg  [31:0] fifo_pat = 32'hc3a50f96;
  reg  [7:0]  r;
  wire        fifo_bit_in = fifo_pat[5'h1f - fifo_idx];
  wire        sck, csn, sdi, sdo, irq_pin, clk_pin, run_pin, pop, done;
  wire [7:0]  ctrl, flags;
  integer     mismatches = 0;
  integer     checks = 0;
  integer     cycles = 0;
  integer     c, v, k;

  always #5 clk_in = ~clk_in;

  // The next payload bit is presented once the current one has been consumed.
  always @(negedge clk_in)
    if (pop)
      fifo_idx <= fifo_idx + 5'h01;

  always @(posedge clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      mismatches = mismatches + 1;
      summarize;
    end
  end

  isp_host_model i_host (.clk_in(clk_in), .sck_out(sck), .chip_select_n_out(csn), .sdi_out(sdi), .sdo_in(sdo));

  isp_irq_host_port i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .chip_select_n_in(csn), .sck_in(sck), .sdi_in(sdi), .sdo_out(sdo),
    .event_in(event_in), .reset_event_in(reset_event_in), .fifo_lock_in(fifo_lock_in),
    .slave_run_in(slave_run_in), .fifo_bit_in(fifo_bit_in), .fifo_status_in(fifo_status_in),
    .fifo_pop_out(pop), .fifo_read_done_out(done), .rx_strobe_in(rx_strobe_in), .rx_data_in(rx_data_in),
    .clk_div_in(clk_div_in), .rx_running_in(rx_running_in), .irq_strobe_pin_out(irq_pin),
    .clock_data_pin_out(clk_pin), .running_data_pin_out(run_pin), .pin_function_control_out(ctrl),
    .event_flags_out(flags));

  task summarize;
  begin
    $display("Comparisons %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  task chk(input [7:0] seen, input [7:0] exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task rd(input [7:0] a, input [7:0] exp);
  begin
    i_host.xfer(`ISP_INSTR_READ, r);
    i_host.xfer(a, r);
    i_host.xfer(8'h00, r);
    chk(r, exp);
  end
  endtask

  task wr(input [7:0] a, input [7:0] d);
  begin
    i_host.xfer(`ISP_INSTR_WRITE, r);
    i_host.xfer(a, r);
    i_host.xfer(d, r);
  end
  endtask

  task srd(input [7:0] a, input [7:0] exp);
  begin
    i_host.sel(1'b1);
    rd(a, exp);
    i_host.sel(1'b0);
  end
  endtask

  task swr(input [7:0] a, input [7:0] d);
  begin
    i_host.sel(1'b1);
    wr(a, d);
    i_host.sel(1'b0);
  end
  endtask

  // One-cycle event pulse, then time for the pin to follow.
  task ev(input [7:0] e, input reg rev);
  begin
    @(negedge clk_in);
    event_in = e;
    reset_event_in = rev;
    @(negedge clk_in);
    event_in = 8'h00;
    reset_event_in = 1'b0;
    repeat (3) @(negedge clk_in);
  end
  endtask

  task t_regs;
  begin
    srd(`ISP_ADDR_FLAGS, `ISP_RST_FLAGS);
    srd(`ISP_ADDR_FLAGS, 8'h00);
    srd(`ISP_ADDR_PIN_CTRL, 8'h00);
    srd(8'h2a, 8'h00);
    srd(`ISP_ADDR_TRACE_ADDR, `ISP_RST_TRACE);
  end
  endtask

  task t_frames;
  begin
    i_host.sel(1'b1);
    wr(8'h30, 8'h5a);
    rd(`ISP_ADDR_TRACE_ADDR, 8'h30);
    wr(`ISP_ADDR_MASK, 8'h0f);
    rd(`ISP_ADDR_TRACE_DATA, 8'h0f);
    i_host.xfer(8'h77, r);
    rd(`ISP_ADDR_TRACE_ADDR, `ISP_ADDR_MASK);
    i_host.sel(1'b0);
  end
  endtask

  task t_reset_ev;
  begin
    swr(`ISP_ADDR_MASK, 8'hff);
    ev(8'h00, 1'b1);
    chk({7'h00, irq_pin}, 8'h00);
    ev(8'h01, 1'b0);
    chk({7'h00, irq_pin}, 8'h01);
    srd(`ISP_ADDR_FLAGS, 8'h00);
    swr(`ISP_ADDR_MASK, 8'h0f);
  end
  endtask

  task t_events;
  begin
    ev(8'h01, 1'b0);
    chk({7'h00, irq_pin}, 8'h01);
    ev(8'h40, 1'b0);
    chk({7'h00, irq_pin}, 8'h00);
    ev(8'h10, 1'b0);
    ev(8'h02, 1'b0);
    srd(`ISP_ADDR_FLAGS, 8'h12);
    repeat (3) @(negedge clk_in);
    chk({7'h00, irq_pin}, 8'h01);
  end
  endtask

  // Data is driven opposite to the clock and running sources; the strobe takes both levels against the idle interrupt level.
  task t_pins;
  begin
    swr(`ISP_ADDR_PIN_CTRL, 8'h20);
    chk(ctrl, 8'h20);
    chk({7'h00, irq_pin}, 8'h00);
    for (c = 0; c < 2; c = c + 1)
    begin
      swr(`ISP_ADDR_PIN_CTRL, c[0] ? 8'h07 : 8'h00);
      for (v = 0; v < 2; v = v + 1)
      begin
        rx_strobe_in = v[0];
        rx_data_in = !v[0];
        clk_div_in = v[0];
        rx_running_in = v[0];
        repeat (2) @(negedge clk_in);
        chk({7'h00, clk_pin}, {7'h00, c[0] ? !v[0] : v[0]});
        chk({7'h00, irq_pin}, {7'h00, c[0] ? v[0] : 1'b1});
        chk({7'h00, run_pin}, {7'h00, c[0] ? !v[0] : v[0]});
      end
    end
    swr(`ISP_ADDR_PIN_CTRL, 8'h00);
  end
  endtask

  // Lock without slave run must not hold the pin; with both it sticks until read-out.
  task t_fifo;
  begin
    swr(`ISP_ADDR_MASK, 8'h00);
    fifo_lock_in = 1'b1;
    slave_run_in = 1'b0;
    ev(8'h08, 1'b0);
    srd(`ISP_ADDR_FLAGS, 8'h08);
    repeat (3) @(negedge clk_in);
    chk({7'h00, irq_pin}, 8'h01);
    slave_run_in = 1'b1;
    fifo_status_in = 8'h20;
    ev(8'h80, 1'b0);
    srd(`ISP_ADDR_FLAGS, 8'h80);
    repeat (3) @(negedge clk_in);
    chk({7'h00, irq_pin}, 8'h00);
    i_host.sel(1'b1);
    i_host.xfer(`ISP_INSTR_FIFO, r);
    for (k = 0; k < 4; k = k + 1)
    begin
      i_host.xfer(8'h00, r);
      chk(r, fifo_pat[31 - 8 * k -: 8]);
    end
    i_host.xfer(8'h00, r);
    chk(r, 8'h20);
    i_host.sel(1'b0);
    chk({7'h00, irq_pin}, 8'h01);
    fifo_lock_in = 1'b0;
  end
  endtask

  // A power-up reset in mid-run forces the fixed pin level whatever the polarity was.
  task t_por;
  begin
    swr(`ISP_ADDR_PIN_CTRL, 8'h20);
    ev(8'h40, 1'b0);
    chk(flags, 8'h40);
    chk({7'h00, irq_pin}, 8'h01);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    chk({7'h00, irq_pin}, 8'h00);
    chk(ctrl, `ISP_RST_PIN_CTRL);
    chk(flags, `ISP_RST_FLAGS);
    @(negedge clk_in);
    srd(`ISP_ADDR_FLAGS, `ISP_RST_FLAGS);
  end
  endtask

  initial
  begin
    event_in = 8'h00;
    reset_event_in = 1'b0;
    fifo_lock_in = 1'b0;
    slave_run_in = 1'b0;
    fifo_status_in = 8'h00;
    rx_strobe_in = 1'b0;
    rx_data_in = 1'b0;
    clk_div_in = 1'b0;
    rx_running_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    t_regs;
    t_frames;
    t_reset_ev;
    t_events;
    t_pins;
    t_fifo;
    t_por;
    summarize;
  end
endmodule // isp_irq_host_port_tb
